// file: mag_pkg.sv
// Package for the circular-buffer address generator: register map, field positions,
// reset values and the request/answer carriers shared by design and bench.
// Assumes a 16-bit word-addressed register port and byte-addressed data pointers.
package mag_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] MAG_OFS_CTRL = 4'h0;
    localparam logic [3:0] MAG_OFS_XSTART = 4'h1;
    localparam logic [3:0] MAG_OFS_XEND = 4'h2;
    localparam logic [3:0] MAG_OFS_YSTART = 4'h3;
    localparam logic [3:0] MAG_OFS_YEND = 4'h4;
    localparam logic [3:0] MAG_OFS_STATUS = 4'h5;

    // Control register fields
    localparam int MAG_XSEL_LSB = 0;
    localparam int MAG_YSEL_LSB = 4;
    localparam int MAG_SEL_W = 4;
    localparam int MAG_YEN_BIT = 14;
    localparam int MAG_XEN_BIT = 15;
    localparam logic [3:0] MAG_SEL_OFF = 4'hF;
    localparam logic [15:0] MAG_CTRL_MASK = 16'hC0FF;

    // Reset values: both selects parked on the disabled code
    localparam logic [15:0] MAG_CTRL_RST = 16'h00FF;
    localparam logic [15:0] MAG_BOUND_RST = 16'h0000;

    // Status register fields
    localparam int MAG_ST_XACT_BIT = 15;
    localparam int MAG_ST_YACT_BIT = 14;
    localparam int MAG_ST_WRAP_LSB = 0;

    // Address generators: 0 = X read, 1 = X write, 2 = Y
    localparam int MAG_NAGU = 3;
    localparam int MAG_AGU_Y = 2;

    typedef struct packed {
        logic valid;
        logic prog_space;
        logic [3:0] sel;
        logic [15:0] ptr;
        logic [15:0] step;
    } mag_req_s;

    typedef struct packed {
        logic valid;
        logic wrapped;
        logic [3:0] sel;
        logic [15:0] ptr;
    } mag_ans_s;
endpackage : mag_pkg

// file: mag_agu.sv
// Circular-buffer address generator for the X read, X write and Y address units.
// Assumes the core presents post-modified pointer requests on ref_clk and takes
// the corrected pointer one cycle later; registers sit on a plain 16-bit port.
//
// Notes on behaviour
// - One circular buffer in X space, one in Y; X also serves program space.
// - Same wrap logic for data-space and program-space pointer accesses.
// - Both lower and upper boundaries are checked, so power-of-two buffers go both ways.
// - Start and end addresses come from four dedicated 16-bit registers.
// - Length follows from end minus start; largest buffer is 32K words.
// - X select in control bits 3:0; all ones disables X read and write wrapping.
// - X wrapping needs X select not all ones and enable bit 15 set.
// - Y select in control bits 7:4; all ones disables Y wrapping.
// - Y wrapping needs Y select not all ones and enable bit 14 set.
// - Y effective addresses that hit the active Y buffer have their least significant bit cleared.
module mag_agu
    import mag_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire mag_req_s agu_req [MAG_NAGU],
    output mag_ans_s agu_ans [MAG_NAGU]
);

    // Register file state
    logic [15:0] ctrl_q;
    logic [15:0] xstart_q;
    logic [15:0] xend_q;
    logic [15:0] ystart_q;
    logic [15:0] yend_q;
    logic [MAG_NAGU-1:0] wrap_seen_q;
    logic [MAG_NAGU-1:0] wrap_seen_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // Write decode
    wire wr_ctrl = reg_wr && (reg_addr == MAG_OFS_CTRL);
    wire wr_xstart = reg_wr && (reg_addr == MAG_OFS_XSTART);
    wire wr_xend = reg_wr && (reg_addr == MAG_OFS_XEND);
    wire wr_ystart = reg_wr && (reg_addr == MAG_OFS_YSTART);
    wire wr_yend = reg_wr && (reg_addr == MAG_OFS_YEND);
    wire wr_status = reg_wr && (reg_addr == MAG_OFS_STATUS);

    // Control fields
    wire [3:0] x_pointer_select = ctrl_q[MAG_XSEL_LSB +: MAG_SEL_W];
    wire [3:0] y_pointer_select = ctrl_q[MAG_YSEL_LSB +: MAG_SEL_W];
    wire x_wrap_enable = ctrl_q[MAG_XEN_BIT];
    wire y_wrap_enable = ctrl_q[MAG_YEN_BIT];

    // Wrapping is live only with a real select code and the enable bit set
    wire x_active = x_wrap_enable && (x_pointer_select != MAG_SEL_OFF);
    wire y_active = y_wrap_enable && (y_pointer_select != MAG_SEL_OFF);

    // A buffer exists only when end lies at or above start; the span is
    // implied, no length field, so 16-bit bounds cap it at 64 Kbytes
    wire x_span_ok = (xend_q >= xstart_q);
    wire y_span_ok = (yend_q >= ystart_q);

    // Status word: live wrap state and sticky per-generator wrap marks
    wire [15:0] status_w = {x_active, y_active, 11'h000, wrap_seen_q};

    // Read mux; unmapped indices read as zero
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                MAG_OFS_CTRL: rdata_d = ctrl_q;
                MAG_OFS_XSTART: rdata_d = xstart_q;
                MAG_OFS_XEND: rdata_d = xend_q;
                MAG_OFS_YSTART: rdata_d = ystart_q;
                MAG_OFS_YEND: rdata_d = yend_q;
                MAG_OFS_STATUS: rdata_d = status_w;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Control register; unimplemented bits are held at zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= MAG_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata & MAG_CTRL_MASK;
        end
    end

    // Buffer boundary registers, one pair per space
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            xstart_q <= MAG_BOUND_RST;
            xend_q <= MAG_BOUND_RST;
            ystart_q <= MAG_BOUND_RST;
            yend_q <= MAG_BOUND_RST;
        end else begin
            if (wr_xstart) xstart_q <= reg_wdata;
            if (wr_xend) xend_q <= reg_wdata;
            if (wr_ystart) ystart_q <= reg_wdata;
            if (wr_yend) yend_q <= reg_wdata;
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Next pointer with boundary correction; returns {wrapped, pointer}.
    // The edge ahead is checked, upper on increment and lower on decrement, which lets power-of-two
    // buffers run either way; one-way buffers never reach the other edge.
    function automatic logic [16:0] wrap_f(
        input logic [15:0] ptr,
        input logic [15:0] step,
        input logic [15:0] lo,
        input logic [15:0] hi,
        input logic on
    );
        logic [15:0] sum;
        logic up;
        logic down;
        logic [16:0] res;
        sum = ptr + step;
        up = !step[15] && (step != 16'h0000);
        down = step[15];
        res = {1'b0, sum};
        if (on && up && (ptr <= hi) && ((sum > hi) || (sum < ptr))) begin
            res = {1'b1, lo};
        end else if (on && down && (ptr >= lo) && ((sum < lo) || (sum > ptr))) begin
            res = {1'b1, hi};
        end
        return res;
    endfunction : wrap_f

    // One slice per address generator: X read, X write, Y
    logic [MAG_NAGU-1:0] wrap_ev;
    genvar gi;
    generate
        for (gi = 0; gi < MAG_NAGU; gi = gi + 1) begin : g_agu
            localparam bit IS_Y = (gi == MAG_AGU_Y);
            logic [16:0] calc;
            mag_ans_s ans_q;
            mag_ans_s ans_d;

            // X and Y each own one buffer; the X pair also covers program
            // space since its pointers reach there by the same path
            wire [3:0] sel_cfg = IS_Y ? y_pointer_select : x_pointer_select;
            wire space_on = IS_Y ? (y_active && y_span_ok) : (x_active && x_span_ok);
            wire [15:0] lo = IS_Y ? ystart_q : xstart_q;
            wire [15:0] hi = IS_Y ? yend_q : xend_q;

            // Program-space flag does not alter the wrap decision
            wire hit = agu_req[gi].valid && space_on && (agu_req[gi].sel == sel_cfg);

            always_comb begin
                calc = wrap_f(agu_req[gi].ptr, agu_req[gi].step, lo, hi, hit);
                ans_d.valid = agu_req[gi].valid;
                ans_d.wrapped = calc[16];
                ans_d.sel = agu_req[gi].sel;
                ans_d.ptr = calc[15:0];
                // Y buffer hits work on words only, so the byte bit is forced clear
                if (IS_Y && hit) begin
                    ans_d.ptr[0] = 1'b0;
                end
            end

            // Answer registered so each output leaves a flip-flop
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    ans_q <= '0;
                end else begin
                    ans_q <= ans_d;
                end
            end

            assign agu_ans[gi] = ans_q;
            assign wrap_ev[gi] = agu_req[gi].valid && calc[16];
        end
    endgenerate

    // Sticky wrap marks: write one to clear, a same-cycle wrap wins
    always_comb begin
        wrap_seen_d = wrap_seen_q;
        if (wr_status) begin
            wrap_seen_d = wrap_seen_q & ~reg_wdata[MAG_ST_WRAP_LSB +: MAG_NAGU];
        end
        wrap_seen_d = wrap_seen_d | wrap_ev;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrap_seen_q <= '0;
        end else begin
            wrap_seen_q <= wrap_seen_d;
        end
    end

endmodule : mag_agu

// file: mag_agu_properties.sv
// Port-level checker for the circular-buffer address generator.
// Assumes registers change only via the register port; bound at the foot of this file.
module mag_agu_props
    import mag_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire mag_req_s agu_req [MAG_NAGU],
    input wire mag_ans_s agu_ans [MAG_NAGU]
);
    logic [15:0] ctl_q;
    logic [15:0] xs_q;
    logic [15:0] xe_q;
    // Unwrapped X read sum and named decode of the shadowed control word
    wire logic [15:0] x0_sum = agu_req[0].ptr + agu_req[0].step;
    wire logic x_on = ctl_q[MAG_XEN_BIT] && ctl_q[3:0] != MAG_SEL_OFF;
    wire logic y_on = ctl_q[MAG_YEN_BIT] && ctl_q[7:4] != MAG_SEL_OFF;
    wire logic y_hit = agu_req[2].valid && y_on && agu_req[2].sel == ctl_q[7:4];
    // Shadow copies, so wrap targets are judged against what software wrote
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= MAG_CTRL_RST;
            xs_q <= MAG_BOUND_RST;
            xe_q <= MAG_BOUND_RST;
        end else if (reg_wr) begin
            if (reg_addr == MAG_OFS_CTRL) ctl_q <= reg_wdata & MAG_CTRL_MASK;
            if (reg_addr == MAG_OFS_XSTART) xs_q <= reg_wdata;
            if (reg_addr == MAG_OFS_XEND) xe_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    AST_RD_CTRL: assert property (reg_rd && reg_addr == MAG_OFS_CTRL |=> reg_rdata == $past(ctl_q))
        else $error("control read back differs");
    AST_ANS_ECHO: assert property (agu_req[1].valid |=> agu_ans[1].valid && agu_ans[1].sel == $past(agu_req[1].sel))
        else $error("answer valid or select lost");
    AST_X0_OFF: assert property (agu_req[0].valid && !x_on |=> !agu_ans[0].wrapped)
        else $error("X read wrapped while disabled");
    AST_X1_OFF: assert property (agu_req[1].valid && !x_on |=> !agu_ans[1].wrapped)
        else $error("X write wrapped while disabled");
    AST_Y_OFF: assert property (agu_req[2].valid && !y_on |=> !agu_ans[2].wrapped)
        else $error("Y wrapped while disabled");
    AST_Y_LSB: assert property (y_hit |=> agu_ans[2].ptr[0] == 1'b0)
        else $error("Y address has odd byte");
    AST_WRAP_START: assert property (agu_req[0].valid && !agu_req[0].step[15]
        |=> !agu_ans[0].wrapped || agu_ans[0].ptr == $past(xs_q))
        else $error("increment wrap not to start");
    AST_WRAP_END: assert property (agu_req[1].valid && agu_req[1].step[15]
        |=> !agu_ans[1].wrapped || agu_ans[1].ptr == $past(xe_q))
        else $error("decrement wrap not to end");
    AST_PASS: assert property (agu_req[0].valid |=> agu_ans[0].wrapped || agu_ans[0].ptr == $past(x0_sum))
        else $error("unwrapped pointer not ptr plus step");
endmodule : mag_agu_props

bind mag_agu mag_agu_props u_props (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .agu_req(agu_req), .agu_ans(agu_ans));

// file: mag_core_model.sv
// Core-side model: issues one post-modify pointer request at a time.
// Assumes the generator answers from its output register at the taking edge itself.
module mag_core_model
    import mag_pkg::*;
(
    input wire logic ref_clk,
    input wire mag_ans_s agu_ans [MAG_NAGU],
    output mag_req_s agu_req [MAG_NAGU]
);
    // Idle requests from time zero
    initial begin
        for (int i = 0; i < MAG_NAGU; i++) agu_req[i] = '0;
    end
    // Callers keep sel off the frame and stack pointers and walk odd lengths one way
    task automatic issue(input int g, input logic p, input logic [3:0] s, input logic [15:0] ptr,
        input logic [15:0] step, output mag_ans_s ans);
        @(posedge ref_clk);
        agu_req[g] <= '{1'b1, p, s, ptr, step};
        @(posedge ref_clk);
        agu_req[g].valid <= 1'b0; // Dropped at the taking edge, so one request only
        #1;
        ans = agu_ans[g];
    endtask : issue
endmodule : mag_core_model

// file: testbench.sv
// Self-checking bench for the circular-buffer address generator.
// Assumes the core model drives all requests; this module drives the register port.
module testbench
    import mag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] P2 = 16'h0002;
    localparam logic [15:0] M2 = 16'hFFFE;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    mag_req_s agu_req [MAG_NAGU];
    mag_ans_s agu_ans [MAG_NAGU];
    int n_mismatch = 0;
    int n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    mag_agu dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .agu_req(agu_req), .agu_ans(agu_ans));
    mag_core_model core (.ref_clk(ref_clk), .agu_ans(agu_ans), .agu_req(agu_req));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Register cycles: strobe for one cycle, read data taken in the slot after
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd
    // One pointer step with its expected next pointer and wrap flag
    task automatic tc(input int g, input logic p, input logic [3:0] s, input logic [15:0] ptr, step, ep,
        input logic w);
        mag_ans_s a;
        core.issue(g, p, s, ptr, step, a);
        check(a.ptr, ep);
        check(16'(a.wrapped), 16'(w));
        check(16'(a.valid), 16'h0001);
        check(16'(a.sel), 16'(s));
    endtask : tc
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // Hang guard: the whole sequence needs far fewer cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(MAG_OFS_CTRL, 16'h00FF);
        rd(MAG_OFS_YEND, 16'h0000);
        wr(MAG_OFS_XSTART, 16'h1000);
        wr(MAG_OFS_XEND, 16'h101E);
        wr(MAG_OFS_YSTART, 16'h2000);
        wr(MAG_OFS_YEND, 16'h200E);
        rd(MAG_OFS_XEND, 16'h101E);
        wr(MAG_OFS_CTRL, 16'hFFF2);
        rd(MAG_OFS_CTRL, 16'hC0F2);
        rd(4'h6, 16'h0000);
        $display("register test done");
        tc(0, 0, 4'h2, 16'h101E, P2, 16'h1000, 1);
        tc(1, 0, 4'h2, 16'h1000, M2, 16'h101E, 1);
        tc(0, 1, 4'h2, 16'h101E, P2, 16'h1000, 1);
        tc(1, 0, 4'h2, 16'h1004, P2, 16'h1006, 0);
        tc(0, 0, 4'h3, 16'h101E, P2, 16'h1020, 0);
        tc(2, 0, 4'hF, 16'h200E, P2, 16'h2010, 0);
        rd(MAG_OFS_STATUS, 16'h8003);
        wr(MAG_OFS_STATUS, 16'h0007);
        rd(MAG_OFS_STATUS, 16'h8000);
        wr(MAG_OFS_CTRL, 16'h405F);
        tc(0, 0, 4'h2, 16'h101E, P2, 16'h1020, 0);
        tc(2, 0, 4'h5, 16'h2003, P2, 16'h2004, 0);
        tc(2, 0, 4'h5, 16'h200E, P2, 16'h2000, 1);
        tc(2, 0, 4'h5, 16'h2000, M2, 16'h200E, 1);
        tc(0, 0, 4'h5, 16'h101E, P2, 16'h1020, 0);
        wr(MAG_OFS_CTRL, 16'h8052);
        tc(2, 0, 4'h5, 16'h200E, P2, 16'h2010, 0);
        wr(MAG_OFS_CTRL, 16'hC0FF);
        tc(1, 0, 4'hF, 16'h101E, P2, 16'h1020, 0);
        $display("wrap test done");
        wr(MAG_OFS_XSTART, 16'h0000);
        wr(MAG_OFS_XEND, 16'hFFFE);
        wr(MAG_OFS_CTRL, 16'h8002);
        tc(0, 0, 4'h2, 16'hFFFE, P2, 16'h0000, 1);
        $display("length test done");
        // Mid-run reset must bring control, X end and status back to their defaults
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(MAG_OFS_CTRL, 16'h00FF);
        rd(MAG_OFS_XEND, 16'h0000);
        rd(MAG_OFS_STATUS, 16'h0000);
        $display("reset test done");
        finish_test();
    end
endmodule : testbench
